// [core/sleep_gate_pkg.sv]
// constants and types for the sleep-mode clock gate enable block
// Behaviour
// - a 32-bit sleep clock gate register at 0x114 holds one clock enable per unit.
// - an enable bit at 1 gives that unit its clock so it works normally.
// - an enable bit at 0 stops that unit's clock and holds it disabled.
// - any access to a unit whose clock is off ends with a bus fault.
// - after reset every bit of the register reads 0.
// - enables come from the run register when running, this one in sleep, the deep-sleep one in deep sleep.
// - the sleep and deep-sleep sets apply only while the auto clock gating bit is set.
// - bits 16, 17 and 18 gate general-purpose counters 0, 1 and 2.
// - bit 4 gates synchronous serial port 0.
// - bit 1 gates asynchronous serial port 1 and bit 0 gates asynchronous serial port 0.
package sleep_gate_pkg;
	localparam logic [11:0] sleep_clock_gate_ctrl_1_addr = 12'h114;
	localparam logic [31:0] sleep_gate_reset = 32'h00000000;
	localparam logic [31:0] sleep_gate_writable = 32'h01070013;
	localparam int          unit_count = 7;
	localparam int          bit_async0 = 0;
	localparam int          bit_async1 = 1;
	localparam int          bit_sync0 = 4;
	localparam int          bit_counter0 = 16;
	localparam int          bit_counter1 = 17;
	localparam int          bit_counter2 = 18;
	localparam int          bit_comparator0 = 24;
	localparam logic [1:0]  htrans_idle = 2'h0;
	localparam logic [1:0]  htrans_nonseq = 2'h2;
	localparam logic [2:0]  hsize_word = 3'h2;
	localparam logic        hresp_okay = 1'h0;
	localparam logic        hresp_error = 1'h1;

	typedef enum logic [1:0] {
		mode_run,
		mode_sleep,
		mode_deep_sleep
	} power_mode_t;

	typedef struct packed {
		logic analog_comparator0_clock_gate;
		logic gp_counter2_clock_gate;
		logic gp_counter1_clock_gate;
		logic gp_counter0_clock_gate;
		logic sync_serial0_clock_gate;
		logic async_serial1_clock_gate;
		logic async_serial0_clock_gate;
	} unit_enables_t;

	typedef enum logic [1:0] {
		bus_idle,
		bus_write,
		bus_read,
		bus_err2
	} bus_state_t;
endpackage

// [core/sleep_clock_gate.sv]
// sleep-mode clock gate register with glitch-free per-unit clock gates
`timescale 1ns/1ns
module sleep_clock_gate (
	input  wire logic                         hclk,
	input  wire logic                         hresetn,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic      [31:0]                  hrdata,
	output logic                              hreadyout,
	output logic                              hresp,
	input  wire logic [31:0]                  run_clock_gate_ctrl_1,
	input  wire logic [31:0]                  deep_sleep_clock_gate_ctrl_1,
	input  wire logic                         auto_clock_gating,
	input  wire sleep_gate_pkg::power_mode_t  power_mode,
	input  wire sleep_gate_pkg::unit_enables_t unit_access,
	output sleep_gate_pkg::unit_enables_t     unit_enable,
	output sleep_gate_pkg::unit_enables_t     unit_fault,
	output logic [sleep_gate_pkg::unit_count-1:0] unit_clk
);
	// bit positions of each unit, ordered as in unit_enables_t (lsb first)
	localparam int unit_bit [sleep_gate_pkg::unit_count] = '{
		sleep_gate_pkg::bit_async0, sleep_gate_pkg::bit_async1,
		sleep_gate_pkg::bit_sync0, sleep_gate_pkg::bit_counter0,
		sleep_gate_pkg::bit_counter1, sleep_gate_pkg::bit_counter2,
		sleep_gate_pkg::bit_comparator0};

	logic [31:0]                  sleep_clock_gate_ctrl_1;
	sleep_gate_pkg::bus_state_t   bus_state;
	logic [31:0]                  selected_set;
	logic [sleep_gate_pkg::unit_count-1:0] latch_en;
	logic                         hit;
	logic                         take;

	function automatic logic addr_hit(input logic [31:0] a);
		return a[11:0] == sleep_gate_pkg::sleep_clock_gate_ctrl_1_addr;
	endfunction

	assign take = hsel && hready && htrans == sleep_gate_pkg::htrans_nonseq;
	assign hit = addr_hit(haddr) && hsize == sleep_gate_pkg::hsize_word;

	// bus slave: writes land one cycle after the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		// hready is high in the last error cycle, so a new address phase
		// taken there must be decoded, not dropped
		if (!hresetn) begin
			bus_state <= sleep_gate_pkg::bus_idle;
		end else if (take && !hit) begin
			bus_state <= sleep_gate_pkg::bus_err2;
		end else if (take && hwrite) begin
			bus_state <= sleep_gate_pkg::bus_write;
		end else if (take) begin
			bus_state <= sleep_gate_pkg::bus_read;
		end else begin
			bus_state <= sleep_gate_pkg::bus_idle;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_clock_gate_ctrl_1 <= sleep_gate_pkg::sleep_gate_reset;
		end else if (bus_state == sleep_gate_pkg::bus_write) begin
			// reserved bits never store, so they read 0
			sleep_clock_gate_ctrl_1 <= hwdata
				& sleep_gate_pkg::sleep_gate_writable;
		end
	end

	// unmapped address or non-word size: two-cycle error response, slave response otherwise okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= sleep_gate_pkg::hresp_okay;
		end else if (take && !hit) begin
			hreadyout <= 1'b0;
			hresp <= sleep_gate_pkg::hresp_error;
		end else if (bus_state == sleep_gate_pkg::bus_err2) begin
			hreadyout <= 1'b1;
			hresp <= sleep_gate_pkg::hresp_error;
		end else begin
			hreadyout <= 1'b1;
			hresp <= sleep_gate_pkg::hresp_okay;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (take && hit && !hwrite) begin
			hrdata <= sleep_clock_gate_ctrl_1;
		end else begin
			hrdata <= 32'h00000000;
		end
	end

	// enable source follows the power mode and the auto gating bit
	always_comb begin
		selected_set = run_clock_gate_ctrl_1;
		if (auto_clock_gating) begin
			case (power_mode)
				sleep_gate_pkg::mode_sleep:
					selected_set = sleep_clock_gate_ctrl_1;
				sleep_gate_pkg::mode_deep_sleep:
					selected_set = deep_sleep_clock_gate_ctrl_1;
				default:
					selected_set = run_clock_gate_ctrl_1;
			endcase
		end
	end

	genvar i;
	generate
		for (i = 0; i < sleep_gate_pkg::unit_count; i++) begin : g_unit
			// registered enable, then a low-phase latch so a mode change
			// never chops a clock high pulse
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					unit_enable[i] <= 1'b0;
				end else begin
					unit_enable[i] <= selected_set[unit_bit[i]];
				end
			end

			always_latch begin
				if (!hclk) begin
					latch_en[i] = unit_enable[i];
				end
			end

			assign unit_clk[i] = hclk & latch_en[i];

			// a unit access while unclocked is flagged as a fault
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					unit_fault[i] <= 1'b0;
				end else begin
					unit_fault[i] <= unit_access[i] && !unit_enable[i];
				end
			end
		end
	endgenerate
endmodule

// [sim/sleep_gate_properties.sv]
// port assertions for the sleep clock gate block
`timescale 1ns/1ns
module sleep_gate_properties (
	input wire logic                          hclk,
	input wire logic                          hresetn,
	input wire logic                          hsel,
	input wire logic [31:0]                   haddr,
	input wire logic [1:0]                    htrans,
	input wire logic [2:0]                    hsize,
	input wire logic                          hwrite,
	input wire logic                          hready,
	input wire logic [31:0]                   hrdata,
	input wire logic                          hreadyout,
	input wire logic                          hresp,
	input wire logic [31:0]                   run_clock_gate_ctrl_1,
	input wire logic [31:0]                   deep_sleep_clock_gate_ctrl_1,
	input wire logic                          auto_clock_gating,
	input wire sleep_gate_pkg::power_mode_t   power_mode,
	input wire sleep_gate_pkg::unit_enables_t unit_access,
	input wire sleep_gate_pkg::unit_enables_t unit_enable,
	input wire sleep_gate_pkg::unit_enables_t unit_fault
);
	wire req = hsel && hready && htrans == sleep_gate_pkg::htrans_nonseq;
	wire ok = haddr[11:0] == sleep_gate_pkg::sleep_clock_gate_ctrl_1_addr
		&& hsize == sleep_gate_pkg::hsize_word;
	function automatic logic [6:0] pick(input logic [31:0] r);
		return {r[24], r[18:16], r[4], r[1:0]};
	endfunction
	sequence err_resp;
		!hreadyout && hresp ##1 hreadyout && hresp;
	endsequence
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ok_ready: assert property (req && ok |=> hreadyout && !hresp)
		else $error("good transfer not answered at once");
	a_err_two: assert property (req && !ok |=> err_resp)
		else $error("bad transfer without two-cycle error");
	a_reserved_zero: assert property ((hrdata & ~32'h01070013) == 32'h0)
		else $error("reserved bit read as one");
	a_rdata_idle: assert property (!(req && !hwrite) |=> hrdata == 32'h0)
		else $error("read data outside a read");
	a_run_set: assert property ((!auto_clock_gating
		|| power_mode == sleep_gate_pkg::mode_run)
		|=> unit_enable == pick($past(run_clock_gate_ctrl_1)))
		else $error("run enables not applied");
	a_deep_set: assert property (auto_clock_gating
		&& power_mode == sleep_gate_pkg::mode_deep_sleep
		|=> unit_enable == pick($past(deep_sleep_clock_gate_ctrl_1)))
		else $error("deep sleep enables not applied");
	a_fault_map: assert property (1'h1 |=>
		unit_fault == $past(unit_access & ~unit_enable))
		else $error("unit fault does not follow access");
	a_reset_clear: assert property ($rose(hresetn) |->
		unit_enable == 7'h0 && unit_fault == 7'h0 && hrdata == 32'h0)
		else $error("outputs not clear after reset");
endmodule

// [sim/gated_unit_model.sv]
// behavioural gated units that count their clock edges
`timescale 1ns/1ns
module gated_unit_model (
	input wire logic [6:0] unit_clk,
	output int             ticks [7]
);
	for (genvar i = 0; i < 7; i++) begin : g_unit
		// a unit only advances while its clock is let through
		always @(posedge unit_clk[i]) ticks[i] <= ticks[i] + 1;
	end
endmodule

// [sim/sleep_clock_gate_test.sv]
// self-checking bench for the sleep clock gate block
`timescale 1ns/1ns
module sleep_clock_gate_test;
	logic                          hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0;
	logic                          hwrite = 1'h0, auto_clock_gating = 1'h1;
	logic [31:0]                   haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
	logic [31:0]                   run_clock_gate_ctrl_1 = 32'h13;
	logic [31:0]                   deep_sleep_clock_gate_ctrl_1 = 32'h70000;
	logic [1:0]                    htrans = 2'h0;
	logic [2:0]                    hsize = 3'h2;
	logic                          hready, hreadyout, hresp, resp;
	logic [6:0]                    unit_clk;
	sleep_gate_pkg::power_mode_t   power_mode = sleep_gate_pkg::mode_sleep;
	sleep_gate_pkg::unit_enables_t unit_access = 7'h0, unit_enable, unit_fault;
	int                            err_count = 0, total_checks = 0;
	int                            ticks [7], t [7];
	int                            pos [7] = '{0, 1, 4, 16, 17, 18, 24};
	assign hready = hreadyout;
	always #20 hclk = ~hclk;
	sleep_clock_gate dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
		.run_clock_gate_ctrl_1, .deep_sleep_clock_gate_ctrl_1,
		.auto_clock_gating, .power_mode, .unit_access, .unit_enable,
		.unit_fault, .unit_clk);
	gated_unit_model units (.unit_clk, .ticks);
	task end_sim;
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	// bounded wait for hready at a rising edge
	task wt;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'h1 && n < 50);
		if (n >= 50) begin
			err_count++;
			end_sim;
		end
	endtask
	task xfer(input logic w, input logic [31:0] a, d, input logic [2:0] s);
		@(posedge hclk);
		{hsel, hwrite, haddr, hsize, htrans} <= {1'h1, w, a, s, 2'h2};
		wt;
		{hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
		wt;
		rdat = hrdata;
		resp = hresp;
	endtask
	task mode(input logic a, sleep_gate_pkg::power_mode_t m, logic [6:0] e);
		@(posedge hclk);
		auto_clock_gating <= a;
		power_mode <= m;
		repeat (2) @(posedge hclk);
		#1 chk(unit_enable, e);
	endtask
	task t_regs;
		xfer(1'h0, 32'h114, 32'h0, 3'h2);
		chk(rdat, 32'h0);
		chk(unit_enable, 32'h0);
		xfer(1'h1, 32'h114, 32'hffffffff, 3'h2);
		xfer(1'h1, 32'h118, 32'h0, 3'h2);
		chk(resp, 1'h1);
		xfer(1'h1, 32'h114, 32'h0, 3'h1);
		chk(resp, 1'h1);
		xfer(1'h0, 32'h114, 32'h0, 3'h2);
		chk(rdat, 32'h01070013);
	endtask
	task t_units;
		@(posedge hclk);
		unit_access <= 7'h7f;
		for (int i = 0; i < 7; i++) begin
			xfer(1'h1, 32'h114, 32'h1 << pos[i], 3'h2);
			@(posedge hclk);
			#1 t = ticks;
			repeat (4) @(posedge hclk);
			#1 chk(unit_enable, 7'h1 << i);
			chk(unit_fault, 7'h7f ^ (7'h1 << i));
			for (int j = 0; j < 7; j++) chk(ticks[j] - t[j], i == j ? 4 : 0);
		end
	endtask
	// mid-run reset must clear the register and the enables again
	task t_reset;
		@(posedge hclk);
		hresetn <= 1'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		#1 chk(unit_enable, 32'h0);
		xfer(1'h0, 32'h114, 32'h0, 3'h2);
		chk(rdat, 32'h0);
	endtask
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'h1;
		t_regs;
		t_units;
		mode(1'h1, sleep_gate_pkg::mode_run, 7'h07);
		mode(1'h1, sleep_gate_pkg::mode_deep_sleep, 7'h38);
		mode(1'h0, sleep_gate_pkg::mode_sleep, 7'h07);
		mode(1'h1, sleep_gate_pkg::mode_sleep, 7'h40);
		t_reset;
		end_sim;
	end
endmodule
bind sleep_clock_gate sleep_gate_properties props (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hsize, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
	.run_clock_gate_ctrl_1, .deep_sleep_clock_gate_ctrl_1,
	.auto_clock_gating, .power_mode, .unit_access, .unit_enable, .unit_fault);
